//--- ccps_top.sv
// Core clock, power and startup control with a Wishbone register slave.
// Assumes a classic Wishbone master on clk_sys and pins from outside.
// Notes on behaviour
// [R1] Host writes ones to both mutes and core run for basic operation.
// [R2] Host programs the converter setup field to 01.
// [R3] Active-low mute bits; a change starts a gradual volume ramp.
// [R4] Core run cleared zeroes accumulators and data in/out registers.
// [R5] Host loads memories with core halted, then restores all three bits.
// [R6] Power bits zero enable sections; a one powers a section down.
// [R7] One ADC power-down bit for both ADCs; one bit per DAC.
// [R8] Reference powers down only when bits 6 and 7 are both set.
// [R9] Last multipurpose pin drives divided core clock when configured.
// [R10] Oscillator on by default; a one in its bit powers it down.
// [R11] Ratio pins decode to 64, 256, 384 or 512 times sample rate.
// [R12] The PLL turns the master clock into the core clock.
// [R13] Double rate needs 32, 128, 192 or 256 times the sample rate.
// [R14] Quad rate needs 16, 64, 96 or 128 times the sample rate.
// [R15] A running master clock must be present at power-up.
// [R16] Ratio pins change only while reset is held low.
// [R17] Ratio mode is latched at reset release; reset is synchronised.
// [R18] Start-up lasts fixed master clock cycles; no access until done. Boot part counts clk_sys cycles; only writes are dropped, reads answer.
// [R19] Reset zeroes control registers and loads boot contents.
`timescale 1ns/10ps
`include "ccps_cfg.svh"
module ccps_top #(
	parameter int PLL_CYCLES = `CCPS_PLL_CYCLES,
	parameter int BOOT_CYCLES =
		(`CCPS_BOOT_NS * `CCPS_CLK_MHZ + 999) / 1000
) (
	// Clock and reset.
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	// Wishbone slave.
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [13:0]           wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// Pins.
	input  wire logic                  master_clock_in,
	input  wire logic                  clk_ratio_sel0,
	input  wire logic                  clk_ratio_sel1,
	output logic                       multipurpose_pin_11,
	output logic                       multipurpose_pin_11_oen,
	// Core status to the analog and processing sections.
	output ccps_pkg::ccps_power_t      powerCtl,
	output ccps_pkg::ccps_clkmode_t    clkMode,
	output logic                       coreClear,
	output logic                       bootDone,
	output logic      [7:0]            adcLevel,
	output logic      [7:0]            dacLevel
);
	import ccps_pkg::*;
	generate
		if (PLL_CYCLES < 1 || BOOT_CYCLES < 1) begin : g_chk
			$error("Start-up counts must be positive.");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and reset release.
	// The ratio code reads {sel0, sel1}, so sel0 is its upper bit.
	logic [2:0] pinSync;
	ccps_sync #(.WIDTH(3)) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.din     ({master_clock_in, clk_ratio_sel0, clk_ratio_sel1}),
		.dout    (pinSync)
	);
	// Four stages match the pin filter's four-cycle delay, so the latch sees settled pins.
	logic [3:0] rstSyncReg;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rstSyncReg <= 4'h0;
		end else begin
			rstSyncReg <= {rstSyncReg[2:0], 1'b1}; // [R17]
		end
	end
	wire logic runEn = rstSyncReg[3];

	////////////////////////////////////////////////////////////////////////
	// Start-up sequencer: PLL lock count, then boot.
	ccps_state_t stReg, stNext;
	logic [31:0] cntReg, cntNext;
	logic        mclkPrevReg, mclkPrevNext;
	logic        latchedReg, latchedNext;
	logic        doneReg, doneNext;
	ccps_clkmode_t modeReg, modeNext;
	wire logic mclkRise = pinSync[2] & ~mclkPrevReg;
	function automatic logic [9:0] ratioOf(input logic [1:0] s);
		case (s)
			2'b00: ratioOf = 10'd64;
			2'b01: ratioOf = 10'd256;
			2'b10: ratioOf = 10'd384;
			default: ratioOf = 10'd512;
		endcase
	endfunction : ratioOf
	always_comb begin
		stNext = stReg;
		cntNext = cntReg;
		mclkPrevNext = pinSync[2];
		latchedNext = latchedReg;
		modeNext = modeReg;
		// Pins are read once after release; later changes are ignored.
		if (runEn && !latchedReg) begin
			latchedNext = 1'b1;
			modeNext.ratioSel = pinSync[1:0]; // [R17]
			modeNext.ratio = ratioOf(pinSync[1:0]); // [R11]
		end
		case (stReg)
			CCPS_ST_PLL: begin
				// Counts master clock edges; a dead clock stalls here.
				if (runEn && mclkRise) begin // [R12]
					if (cntReg == 32'(PLL_CYCLES - 1)) begin // [R18]
						stNext = CCPS_ST_BOOT;
						cntNext = 32'h0;
					end else begin
						cntNext = cntReg + 32'h1;
					end
				end
			end
			CCPS_ST_BOOT: begin
				if (cntReg == 32'(BOOT_CYCLES - 1)) begin // [R18]
					stNext = CCPS_ST_RUN;
					cntNext = 32'h0;
				end else begin
					cntNext = cntReg + 32'h1;
				end
			end
			default: begin
				stNext = CCPS_ST_RUN;
			end
		endcase
		doneNext = (stNext == CCPS_ST_RUN);
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stReg <= CCPS_ST_PLL;
			cntReg <= 32'h0;
			mclkPrevReg <= 1'b0;
			latchedReg <= 1'b0;
			modeReg <= '0;
			doneReg <= 1'b0;
		end else begin
			stReg <= stNext;
			cntReg <= cntNext;
			mclkPrevReg <= mclkPrevNext;
			latchedReg <= latchedNext;
			modeReg <= modeNext;
			doneReg <= doneNext;
		end
	end
	wire logic ready = doneReg;

	////////////////////////////////////////////////////////////////////////
	// Register file and Wishbone slave.
	logic [15:0] coreReg, coreNext, soutReg, soutNext, mpReg, mpNext;
	logic [15:0] pwrReg, pwrNext, oscReg, oscNext, convReg, convNext;
	logic        ackReg, ackNext;
	logic [31:0] datReg, datNext;
	wire logic [11:0] idx = wb_adr_i[13:2];
	wire logic req = wb_cyc_i & wb_stb_i & ~ackReg;
	wire logic wr = req & wb_we_i & ready;
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : merge
	always_comb begin
		coreNext = coreReg;
		soutNext = soutReg;
		mpNext = mpReg;
		pwrNext = pwrReg;
		oscNext = oscReg;
		convNext = convReg;
		ackNext = req;
		datNext = 32'h0;
		// Writes before start-up ends are dropped but still acknowledged.
		if (wr && idx == `CCPS_IDX_CORE) begin
			coreNext = merge(coreReg, wb_dat_i, wb_sel_i); // [R3]
		end else if (wr && idx == `CCPS_IDX_SOUT) begin
			soutNext = merge(soutReg, wb_dat_i, wb_sel_i);
		end else if (wr && idx == `CCPS_IDX_MPCFG) begin
			mpNext = merge(mpReg, wb_dat_i, wb_sel_i);
		end else if (wr && idx == `CCPS_IDX_PWR) begin
			pwrNext = merge(pwrReg, wb_dat_i, wb_sel_i); // [R6]
		end else if (wr && idx == `CCPS_IDX_OSC) begin
			oscNext = merge(oscReg, wb_dat_i, wb_sel_i); // [R10]
		end else if (wr && idx == `CCPS_IDX_CONV) begin
			convNext = merge(convReg, wb_dat_i, wb_sel_i);
		end
		if (!req || wb_we_i) begin
			datNext = 32'h0;
		end else if (idx == `CCPS_IDX_CORE) begin
			datNext = {16'h0, coreReg};
		end else if (idx == `CCPS_IDX_SOUT) begin
			datNext = {16'h0, soutReg};
		end else if (idx == `CCPS_IDX_MPCFG) begin
			datNext = {16'h0, mpReg};
		end else if (idx == `CCPS_IDX_PWR) begin
			datNext = {16'h0, pwrReg};
		end else if (idx == `CCPS_IDX_OSC) begin
			datNext = {16'h0, oscReg};
		end else if (idx == `CCPS_IDX_CONV) begin
			datNext = {16'h0, convReg};
		end else if (idx == `CCPS_IDX_STAT) begin
			datNext = {16'h0, 1'b0, ready, stReg, modeReg.ratioSel, modeReg.ratio};
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			coreReg <= `CCPS_REG_RESET; // [R19]
			soutReg <= `CCPS_REG_RESET;
			mpReg <= `CCPS_REG_RESET;
			pwrReg <= `CCPS_REG_RESET; // [R6]
			oscReg <= `CCPS_REG_RESET; // [R10]
			convReg <= `CCPS_REG_RESET;
			ackReg <= 1'b0;
			datReg <= 32'h0;
		end else begin
			coreReg <= coreNext;
			soutReg <= soutNext;
			mpReg <= mpNext;
			pwrReg <= pwrNext;
			oscReg <= oscNext;
			convReg <= convNext;
			ackReg <= ackNext;
			datReg <= datNext;
		end
	end
	assign wb_ack_o = ackReg;
	assign wb_dat_o = datReg;

	////////////////////////////////////////////////////////////////////////
	// Power, core clear and mute ramps.
	ccps_power_t pwrOutReg, pwrOutNext;
	logic        clearReg, clearNext;
	always_comb begin
		pwrOutNext.adcPowerDown = pwrReg[`CCPS_BIT_ADCPD]; // [R7]
		pwrOutNext.dacPowerDown = pwrReg[`CCPS_BIT_DACPD_LO +: 4]; // [R7]
		pwrOutNext.refPowerDown =
			pwrReg[`CCPS_BIT_REF_A] & pwrReg[`CCPS_BIT_REF_B]; // [R8]
		pwrOutNext.oscPowerDown = oscReg[`CCPS_BIT_OSCPD]; // [R10]
		// Held clear until boot is done, so no stale data leaks out.
		clearNext = ~coreReg[`CCPS_BIT_CORERUN] | ~ready; // [R4]
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pwrOutReg <= '0;
			clearReg <= 1'b1;
		end else begin
			pwrOutReg <= pwrOutNext;
			clearReg <= clearNext;
		end
	end
	assign powerCtl = pwrOutReg;
	assign coreClear = clearReg;
	assign clkMode = modeReg;
	assign bootDone = ready;

	logic [7:0] tickCntReg, tickCntNext;
	always_comb begin
		tickCntNext = tickCntReg + 8'h01;
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tickCntReg <= 8'h00;
		end else begin
			tickCntReg <= tickCntNext;
		end
	end
	wire logic rampTick = (tickCntReg == 8'hff);
	ccps_ramp u_adc_ramp (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.tick    (rampTick),
		.unmute  (coreReg[`CCPS_BIT_ADCMUTE]), // [R3]
		.level   (adcLevel)
	);
	ccps_ramp u_dac_ramp (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.tick    (rampTick),
		.unmute  (coreReg[`CCPS_BIT_DACMUTE]), // [R3]
		.level   (dacLevel)
	);

	////////////////////////////////////////////////////////////////////////
	// Bit clock output on the last multipurpose pin.
	logic [3:0] divReg, divNext;
	logic       bclkReg, bclkNext, oenReg, oenNext;
	wire logic bclkOn = (mpReg[`CCPS_BIT_MULTIPURPOSE_PIN_11_LO +: 4] == `CCPS_MULTIPURPOSE_PIN_11_BCLK) &
		soutReg[`CCPS_BIT_SOMASTER];
	wire logic [1:0] obf = soutReg[`CCPS_BIT_OBF_LO +: 2];
	always_comb begin
		divNext = divReg + 4'h1;
		bclkNext = bclkReg;
		oenNext = ~bclkOn;
		// Half period 1, 2, 4 or 8 cycles of the core clock.
		// A lowered setting takes effect at once instead of wrapping.
		if (!bclkOn) begin // [R9]
			divNext = 4'h0;
			bclkNext = 1'b0;
		end else if (divReg >= 4'((1 << obf) - 1)) begin // [R9]
			divNext = 4'h0;
			bclkNext = ~bclkReg;
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			divReg <= 4'h0;
			bclkReg <= 1'b0;
			oenReg <= 1'b1;
		end else begin
			divReg <= divNext;
			bclkReg <= bclkNext;
			oenReg <= oenNext;
		end
	end
	assign multipurpose_pin_11 = bclkReg;
	assign multipurpose_pin_11_oen = oenReg;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	refPd_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
		powerCtl.refPowerDown == $past(pwrReg[6] & pwrReg[7]))
		else $error("Reference power-down mismatch.");
	adcPd_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R7]
		$rose(pwrReg[0]) |=> powerCtl.adcPowerDown)
		else $error("ADC power-down not applied.");
	oscPd_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
		$rose(oscReg[0]) |=> powerCtl.oscPowerDown)
		else $error("Oscillator power-down not applied.");
	coreClr_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
		!coreReg[2] |=> coreClear)
		else $error("Core not cleared while halted.");
	noEarly_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R18]
		!ready |=> $stable(coreReg) && $stable(pwrReg))
		else $error("Register changed before start-up ended.");
	modeHold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R17]
		latchedReg |=> $stable(clkMode))
		else $error("Clock mode changed after latching.");
	ratio_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
		latchedReg && clkMode.ratioSel == 2'b01 |-> clkMode.ratio == 10'd256)
		else $error("Ratio decode wrong.");
	bclkOff_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
		!bclkOn [*2] |-> multipurpose_pin_11_oen && !multipurpose_pin_11)
		else $error("Pin driven while not configured.");
	bclkDiv_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
		bclkOn && obf == 2'b00 && $past(bclkOn) && $past(obf) == 2'b00
		&& $past(bclkOn, 2) |-> multipurpose_pin_11 != $past(multipurpose_pin_11))
		else $error("Bit clock divider wrong.");
	ramp_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R3]
		(adcLevel != $past(adcLevel)) |-> $past(rampTick))
		else $error("Level moved without a ramp step.");
endmodule : ccps_top

//--- ccps_cfg.svh
// Offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from ccps_top, ccps_ramp and the bench.
`ifndef CCPS_CFG_SVH
`define CCPS_CFG_SVH
`define CCPS_IDX_CORE      12'h81c
`define CCPS_IDX_SOUT      12'h81e
`define CCPS_IDX_MPCFG     12'h821
`define CCPS_IDX_PWR       12'h822
`define CCPS_IDX_OSC       12'h826
`define CCPS_IDX_CONV      12'h827
`define CCPS_IDX_STAT      12'h828
`define CCPS_BIT_ADCMUTE   4
`define CCPS_BIT_DACMUTE   3
`define CCPS_BIT_CORERUN   2
`define CCPS_BIT_RATE_LO   0
`define CCPS_BIT_OBF_LO    0
`define CCPS_BIT_SOMASTER  2
`define CCPS_BIT_MULTIPURPOSE_PIN_11_LO   12
`define CCPS_MULTIPURPOSE_PIN_11_BCLK     4'h1
`define CCPS_BIT_ADCPD     0
`define CCPS_BIT_DACPD_LO  1
`define CCPS_BIT_REF_A     6
`define CCPS_BIT_REF_B     7
`define CCPS_BIT_OSCPD     0
`define CCPS_REG_RESET     16'h0000
`define CCPS_PLL_CYCLES    218
`define CCPS_BOOT_NS       42000
`define CCPS_CLK_MHZ       125
`define CCPS_RAMP_STEPS    64
`endif

//--- ccps_pkg.sv
// Types shared by the clock and power setup block.
// Assumes ccps_cfg.svh supplies the numeric constants.
package ccps_pkg;
	typedef enum logic [1:0] {
		CCPS_ST_PLL  = 2'b00,
		CCPS_ST_BOOT = 2'b01,
		CCPS_ST_RUN  = 2'b10
	} ccps_state_t;
	typedef struct packed {
		logic       adcPowerDown;
		logic [3:0] dacPowerDown;
		logic       refPowerDown;
		logic       oscPowerDown;
	} ccps_power_t;
	typedef struct packed {
		logic [1:0] ratioSel;
		logic [9:0] ratio;
	} ccps_clkmode_t;
endpackage : ccps_pkg

//--- ccps_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/10ps
module ccps_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// Data.
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1Reg, s2Reg, s3Reg, outReg, outNext;
	generate
		if (WIDTH < 1) begin : g_chk
			$error("WIDTH must be positive.");
		end
	endgenerate
	always_comb begin
		outNext = (s2Reg == s3Reg) ? s3Reg : outReg;
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s1Reg  <= '0;
			s2Reg  <= '0;
			s3Reg  <= '0;
			outReg <= '0;
		end else begin
			s1Reg  <= din;
			s2Reg  <= s1Reg;
			s3Reg  <= s2Reg;
			outReg <= outNext;
		end
	end
	assign dout = outReg;
endmodule : ccps_sync

//--- ccps_ramp.sv
// Per-converter volume ramp toward full or zero level.
// Assumes one step per tick pulse from the parent.
`timescale 1ns/10ps
`include "ccps_cfg.svh"
module ccps_ramp #(
	parameter int STEPS = `CCPS_RAMP_STEPS
) (
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Control.
	input  wire logic       tick,
	input  wire logic       unmute,
	output logic      [7:0] level
);
	localparam logic [7:0] TOP = 8'(STEPS);
	logic [7:0] levelReg, levelNext;
	generate
		if (STEPS < 1 || STEPS > 255) begin : g_chk
			$error("STEPS out of range.");
		end
	endgenerate
	// Gradual steps avoid clicks when a mute bit changes.
	always_comb begin
		levelNext = levelReg;
		if (tick && unmute && levelReg < TOP) begin
			levelNext = levelReg + 8'h01;
		end else if (tick && !unmute && levelReg != 8'h00) begin
			levelNext = levelReg - 8'h01;
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			levelReg <= 8'h00;
		end else begin
			levelReg <= levelNext;
		end
	end
	assign level = levelReg;
endmodule : ccps_ramp

//--- ccps_clock_source.sv
// Model of the external master clock source and ratio pin driver.
// Assumes the bench owns reset and asks for a ratio code {sel0, sel1}.
`timescale 1ns/10ps
module ccps_clock_source #(
	parameter int HALF_NS = 40
) (
	// Reset seen by the device.
	input  wire logic       resetn,
	// Requested ratio code.
	input  wire logic [1:0] ratioReq,
	// Pins.
	output logic            master_clock_in,
	output logic            clk_ratio_sel0,
	output logic            clk_ratio_sel1
);
	////////////////////////////////////////////////////////////////////
	// The clock runs from time zero, so the startup count can end.
	// A slow half period lets the pin filter see every edge.
	initial begin
		master_clock_in = 1'b0;
		forever #(HALF_NS) master_clock_in = ~master_clock_in;
	end
	////////////////////////////////////////////////////////////////////
	// Only normal-rate ratios are offered, as no rate-reduced mode runs.
	// New requests reach the pins only while reset is held low.
	always_latch begin
		if (!resetn) begin
			clk_ratio_sel0 = ratioReq[1];
			clk_ratio_sel1 = ratioReq[0];
		end
	end
endmodule : ccps_clock_source

//--- testbench.sv
// Self-checking bench for the clock and power setup block.
// Assumes ccps_cfg.svh and ccps_pkg are compiled before this file.
`timescale 1ns/10ps
`include "ccps_cfg.svh"
module testbench;
	import ccps_pkg::*;
	logic          clk_sys;
	logic          resetn;
	logic          wbCyc;
	logic          wbStb;
	logic          wbWe;
	logic [13:0]   wbAdr;
	logic [3:0]    wbSel;
	logic [31:0]   wbDatW;
	logic [31:0]   wbDatR;
	logic          wbAck;
	logic          mclk;
	logic          sel0;
	logic          sel1;
	logic          mpPin;
	logic          mpOen;
	ccps_power_t   powerCtl;
	ccps_clkmode_t clkMode;
	logic          coreClear;
	logic          bootDone;
	logic [7:0]    adcLevel;
	logic [7:0]    dacLevel;
	logic [1:0]    ratioReq;
	logic [31:0]   rd;
	int            nMismatch = 0;
	int            totalChecks = 0;
	logic [9:0]    ratios [4] = '{10'd64, 10'd256, 10'd384, 10'd512};
	logic [15:0]   pwrVals [10] = '{16'h0001, 16'h0002, 16'h0004,
		16'h0008, 16'h0010, 16'h0040, 16'h0080, 16'h00c0, 16'h00df,
		16'h0000};

	ccps_top #(.BOOT_CYCLES(4)) i_dut (
		.clk_sys(clk_sys), .resetn(resetn),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
		.wb_dat_o(wbDatR), .wb_ack_o(wbAck),
		.master_clock_in(mclk), .clk_ratio_sel0(sel0),
		.clk_ratio_sel1(sel1), .multipurpose_pin_11(mpPin),
		.multipurpose_pin_11_oen(mpOen), .powerCtl(powerCtl),
		.clkMode(clkMode), .coreClear(coreClear), .bootDone(bootDone),
		.adcLevel(adcLevel), .dacLevel(dacLevel));

	ccps_clock_source i_src (
		.resetn(resetn), .ratioReq(ratioReq),
		.master_clock_in(mclk), .clk_ratio_sel0(sel0),
		.clk_ratio_sel1(sel1));

	////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic summarize();
		if (nMismatch == 0 && totalChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One classic cycle; the request stands until ack is seen high.
	task automatic wbXfer(input logic we, input logic [11:0] idx,
			input logic [15:0] wd, output logic [31:0] data);
		int n;
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbSel <= 4'h3;
		wbDatW <= {16'h0000, wd};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wbAck !== 1'b1 && n < 64);
		data = wbDatR;
		check(32'(wbAck), 32'h1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask : wbXfer

	task automatic wr(input logic [11:0] idx, input logic [15:0] v);
		wbXfer(1'b1, idx, v, rd);
	endtask : wr

	task automatic rdChk(input logic [11:0] idx, input logic [31:0] exp);
		wbXfer(1'b0, idx, 16'h0000, rd);
		check(rd, exp);
	endtask : rdChk

	task automatic doReset(input logic [1:0] code);
		@(posedge clk_sys);
		resetn <= 1'b0;
		ratioReq <= code;
		repeat (16) @(posedge clk_sys);
		check(32'(powerCtl), 32'h0);
		check(32'(coreClear), 32'h1);
		check(32'(mpOen), 32'h1);
		check(32'(bootDone), 32'h0);
		resetn <= 1'b1;
	endtask : doReset

	////////////////////////////////////////////////////////////////////
	task automatic testRatio();
		for (int i = 0; i < 4; i++) begin
			doReset(i[1:0]);
			repeat (12) @(posedge clk_sys);
			check(32'(clkMode.ratio), 32'(ratios[i]));
			check(32'(clkMode.ratioSel), 32'(i[1:0]));
		end
	endtask : testRatio

	// A write during startup must be dropped; registers come up zero.
	task automatic testBoot();
		int n;
		doReset(2'b01);
		repeat (8) @(posedge clk_sys);
		wr(`CCPS_IDX_PWR, 16'h00ff);
		n = 0;
		while (bootDone !== 1'b1 && n < 6000) begin
			@(posedge clk_sys);
			n++;
		end
		check(32'(bootDone), 32'h1);
		rdChk(`CCPS_IDX_PWR, 32'h0);
		check(32'(powerCtl), 32'h0);
		rdChk(`CCPS_IDX_CORE, 32'h0);
		wbXfer(1'b0, `CCPS_IDX_STAT, 16'h0000, rd);
		check(32'(rd[14]), 32'h1);
	endtask : testBoot

	task automatic testPower();
		logic [15:0] v;
		for (int i = 0; i < 10; i++) begin
			v = pwrVals[i];
			wr(`CCPS_IDX_PWR, v);
			repeat (2) @(posedge clk_sys);
			check(32'(powerCtl),
				32'({v[0], v[4:1], v[6] & v[7], 1'b0}));
			rdChk(`CCPS_IDX_PWR, 32'(v));
		end
		wr(`CCPS_IDX_OSC, 16'h0001);
		repeat (2) @(posedge clk_sys);
		check(32'(powerCtl.oscPowerDown), 32'h1);
		wr(`CCPS_IDX_OSC, 16'h0000);
		repeat (2) @(posedge clk_sys);
		check(32'(powerCtl.oscPowerDown), 32'h0);
		wr(`CCPS_IDX_CONV, 16'h0001);
		rdChk(`CCPS_IDX_CONV, 32'h1);
		wr(12'h800, 16'hffff);
		rdChk(12'h800, 32'h0);
	endtask : testPower

	// Half period in clk_sys cycles is two to the power of the field.
	task automatic testBitClk();
		int n;
		logic v;
		wr(`CCPS_IDX_SOUT, 16'h0004);
		repeat (40) @(posedge clk_sys);
		check(32'(mpOen), 32'h1);
		wr(`CCPS_IDX_MPCFG, 16'h1000);
		for (int f = 0; f < 4; f++) begin
			wr(`CCPS_IDX_SOUT, {14'h0001, f[1:0]});
			repeat (40) @(posedge clk_sys);
			check(32'(mpOen), 32'h0);
			v = mpPin;
			n = 0;
			while (mpPin === v && n < 40) begin
				@(posedge clk_sys);
				n++;
			end
			v = mpPin;
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
			end while (mpPin === v && n < 40);
			check(32'(n), 32'(1 << f));
		end
		wr(`CCPS_IDX_SOUT, 16'h0000);
		repeat (4) @(posedge clk_sys);
		check(32'(mpOen), 32'h1);
	endtask : testBitClk

	task automatic testCore();
		check(32'(coreClear), 32'h1);
		wr(`CCPS_IDX_CORE, 16'h001c);
		repeat (2) @(posedge clk_sys);
		check(32'(coreClear), 32'h0);
		rdChk(`CCPS_IDX_CORE, 32'h1c);
		repeat (256 * 66) @(posedge clk_sys);
		check(32'(adcLevel), 32'd64);
		check(32'(dacLevel), 32'd64);
		wr(`CCPS_IDX_CORE, 16'h0010);
		repeat (2) @(posedge clk_sys);
		check(32'(coreClear), 32'h1);
		repeat (600) @(posedge clk_sys);
		check(32'(dacLevel inside {[60:63]}), 32'h1);
		repeat (256 * 66) @(posedge clk_sys);
		check(32'(adcLevel), 32'd64);
		check(32'(dacLevel), 32'd0);
		wr(`CCPS_IDX_CORE, 16'h001c);
		repeat (2) @(posedge clk_sys);
		check(32'(coreClear), 32'h0);
	endtask : testCore

	////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		ratioReq = 2'b01;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 14'h0000;
		wbSel = 4'h0;
		wbDatW = 32'h00000000;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		testRatio();
		testBoot();
		testPower();
		testBitClk();
		testCore();
		summarize();
	end

	// The tests need about 37000 cycles; over twice that means a hang.
	initial begin
		repeat (90000) @(posedge clk_sys);
		nMismatch++;
		summarize();
	end
endmodule : testbench
